/* verilog/mct_pkg.sv */
package mct_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_PRESCALE = 8'h08;
	localparam logic [7:0] OFF_PSCNT = 8'h0C;
	localparam logic [7:0] OFF_MCTRL = 8'h10;
	localparam logic [7:0] OFF_MATCH0 = 8'h14;
	localparam logic [7:0] OFF_MATCH1 = 8'h18;
	localparam logic [7:0] OFF_MATCH2 = 8'h1C;
	localparam logic [7:0] OFF_MATCH3 = 8'h20;
	localparam logic [7:0] OFF_CAPCTRL = 8'h24;
	localparam logic [7:0] OFF_CAPTURE = 8'h28;
	localparam logic [7:0] OFF_EXTM = 8'h2C;
	localparam logic [7:0] OFF_PWM = 8'h30;
	localparam logic [7:0] OFF_ISTAT = 8'h34;
	localparam logic [7:0] OFF_IMASK = 8'h38;

	// number of match channels
	localparam int NUM_MATCH = 4;

	// control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_RST = 1;
	localparam int CTRL_CNTMODE = 2;
	localparam logic [2:0] CTRL_RESET_VAL = 3'h0;

	// match control: three bits per channel at 3*i
	localparam int MC_IRQ = 0;
	localparam int MC_RST = 1;
	localparam int MC_STOP = 2;
	localparam logic [11:0] MCTRL_RESET_VAL = 12'h000;

	// capture control fields
	localparam int CAP_RISE = 0;
	localparam int CAP_FALL = 1;
	localparam int CAP_IRQ = 2;
	localparam int CAP_CLR_RISE = 3;
	localparam int CAP_CLR_FALL = 4;
	localparam logic [4:0] CAPCTRL_RESET_VAL = 5'h00;

	// external match: state in [3:0], 2-bit action per channel from bit 4
	localparam int EXTM_ACT_LSB = 4;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [7:0] EXTM_ACT_RESET_VAL = 8'h00;

	// interrupt status: match flags [3:0], capture flag at bit 4
	localparam int IRQ_CAP_BIT = 4;
	localparam logic [4:0] IRQ_RESET_VAL = 5'h00;
endpackage

/* verilog/mct_match_if.sv */
interface mct_match_if #(
	parameter int W = 32
);
	logic [W-1:0] count;
	logic [W-1:0] mval [4];
	logic tick;
	logic [7:0] act;
	logic [3:0] pwm_en;
	logic [3:0] wr_en;
	logic [3:0] wr_val;
	logic [3:0] hit;
	logic [3:0] out;

	modport core (
		output count, mval, tick, act, pwm_en, wr_en, wr_val,
		input hit, out
	);
	modport unit (
		input count, mval, tick, act, pwm_en, wr_en, wr_val,
		output hit, out
	);
endinterface

/* verilog/mct_capture.sv */
module mct_capture (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// pin and configuration
	input wire logic cap_pin,
	input wire logic [4:0] cfg,
	// events, one-cycle pulses, and the synchronised pin level
	output logic cap_evt,
	output logic clr_evt,
	output logic cap_level
);
	logic sync1_reg;
	logic sync2_reg;
	logic last_reg;
	logic [1:0] arm_reg;
	logic rise;
	logic fall;

	// two-flop synchroniser, then a history flop for edge detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg <= 1'b0;
		end else if (ce) begin
			sync1_reg <= cap_pin;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
		end
	end

	// edges count only once the history flop holds a real pin sample,
	// so a pin that idles high gives no false edge after reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arm_reg <= 2'h0;
		end else if (ce && arm_reg != 2'h3) begin
			arm_reg <= arm_reg + 2'h1;
		end
	end

	assign rise = ce && (arm_reg == 2'h3) && sync2_reg && !last_reg;
	assign fall = ce && (arm_reg == 2'h3) && !sync2_reg && last_reg;
	assign cap_level = sync2_reg;

	// selected edges give capture and clear events
	assign cap_evt = (rise && cfg[mct_pkg::CAP_RISE]) || (fall && cfg[mct_pkg::CAP_FALL]);
	assign clr_evt = (rise && cfg[mct_pkg::CAP_CLR_RISE]) ||
		(fall && cfg[mct_pkg::CAP_CLR_FALL]);
endmodule

/* verilog/mct_match_unit.sv */
module mct_match_unit #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// link to the counter core
	mct_match_if.unit m
);
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_ch
			logic [1:0] act;
			assign act = m.act[2*i +: 2];
			// equality with the count while the counter advances
			assign m.hit[i] = m.tick && (m.count == m.mval[i]);

			// output pin: software write, pwm level, or match action
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					m.out[i] <= 1'b0;
				end else if (ce) begin
					if (m.wr_en[i]) begin
						m.out[i] <= m.wr_val[i];
					end else if (m.pwm_en[i]) begin
						m.out[i] <= (m.count >= m.mval[i]);
					end else if (m.hit[i]) begin
						case (act)
							mct_pkg::ACT_LOW: m.out[i] <= 1'b0;
							mct_pkg::ACT_HIGH: m.out[i] <= 1'b1;
							mct_pkg::ACT_TOGGLE: m.out[i] <= !m.out[i];
							default: m.out[i] <= m.out[i];
						endcase
					end
				end
			end
		end
	endgenerate
endmodule

/* verilog/mct_timer.sv */
// Local design decisions: the address map and the APB register port.
module mct_timer #(
	parameter int W = 32
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic cap_in,
	output logic [3:0] match_out,
	// adc triggers
	output logic [3:0] adc_trig_match,
	output logic adc_trig_cap,
	// interrupt
	output logic irq
);
	// refuse widths that the counter and the read path cannot serve
	if (W < 2 || W > 32) begin : g_bad_width
		$error("mct_timer: W must lie in 2..32");
	end

	logic [2:0] ctrl_reg;
	logic [W-1:0] tc_reg;
	logic [W-1:0] pr_reg;
	logic [W-1:0] pc_reg;
	logic [11:0] mctrl_reg;
	logic [W-1:0] match_reg [4];
	logic [4:0] capctrl_reg;
	logic [W-1:0] cap_reg;
	logic [7:0] extact_reg;
	logic [3:0] pwm_reg;
	logic [4:0] istat_reg;
	logic [4:0] imask_reg;
	logic [4:0] rd_clr_reg;
	logic [31:0] rdata_next;
	logic mapped;
	logic wr_done;
	logic rd_done;
	logic cap_evt;
	logic clr_evt;
	logic cap_level;
	logic tick;
	logic pre_wrap;
	logic [3:0] hit;
	logic [3:0] rst_hit;
	logic [3:0] stop_hit;
	logic [3:0] irq_hit;
	logic [4:0] ev_set;

	mct_match_if #(.W(W)) mif ();

	mct_capture u_cap (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.cap_pin(cap_in),
		.cfg(capctrl_reg),
		.cap_evt(cap_evt),
		.clr_evt(clr_evt),
		.cap_level(cap_level)
	);

	mct_match_unit #(.W(W)) u_match (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.m(mif.unit)
	);

	// apb completion strobes
	assign wr_done = ce && psel && penable && pready && pwrite;
	assign rd_done = ce && psel && penable && pready && !pwrite;

	// counting: prescaler in timer mode, capture edges in counter mode
	assign pre_wrap = (pc_reg == pr_reg);
	assign tick = ctrl_reg[mct_pkg::CTRL_EN] && !ctrl_reg[mct_pkg::CTRL_RST] &&
		(ctrl_reg[mct_pkg::CTRL_CNTMODE] ? cap_evt : pre_wrap);

	// link to the match unit
	assign mif.count = tc_reg;
	assign mif.tick = tick && ce;
	assign mif.act = extact_reg;
	assign mif.pwm_en = pwm_reg;
	assign mif.wr_en = (wr_done && paddr == mct_pkg::OFF_EXTM) ? 4'hF : 4'h0;
	assign mif.wr_val = pwdata[3:0];
	assign hit = mif.hit;
	assign match_out = mif.out;

	// per-channel match actions
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_mact
			assign mif.mval[g] = match_reg[g];
			assign rst_hit[g] = hit[g] && mctrl_reg[3*g + mct_pkg::MC_RST];
			assign stop_hit[g] = hit[g] && mctrl_reg[3*g + mct_pkg::MC_STOP];
			assign irq_hit[g] = hit[g] && mctrl_reg[3*g + mct_pkg::MC_IRQ];

			// match value of this channel, one word apart from the previous one
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					match_reg[g] <= '0;
				end else if (wr_done && paddr == mct_pkg::OFF_MATCH0 + 8'(4 * g)) begin
					match_reg[g] <= pwdata[W-1:0];
				end
			end
		end
	endgenerate

	assign ev_set = {cap_evt && capctrl_reg[mct_pkg::CAP_IRQ], irq_hit};

	// control register; a stop match clears the enable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_reg <= mct_pkg::CTRL_RESET_VAL;
		end else if (ce) begin
			if (wr_done && paddr == mct_pkg::OFF_CTRL) begin
				ctrl_reg <= pwdata[2:0];
			end
			if (|stop_hit) begin
				ctrl_reg[mct_pkg::CTRL_EN] <= 1'b0;
			end
		end
	end

	// prescale counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_reg <= '0;
		end else if (ce) begin
			if (ctrl_reg[mct_pkg::CTRL_RST] || clr_evt) begin
				pc_reg <= '0;
			end else if (ctrl_reg[mct_pkg::CTRL_EN] && !ctrl_reg[mct_pkg::CTRL_CNTMODE]) begin
				pc_reg <= pre_wrap ? '0 : pc_reg + 1'b1;
			end
		end
	end

	// main counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tc_reg <= '0;
		end else if (ce) begin
			if (ctrl_reg[mct_pkg::CTRL_RST] || clr_evt) begin
				tc_reg <= '0;
			end else if (wr_done && paddr == mct_pkg::OFF_COUNT) begin
				tc_reg <= pwdata[W-1:0];
			end else if (tick) begin
				if (|rst_hit) begin
					tc_reg <= '0;
				end else if (!(|stop_hit)) begin
					tc_reg <= tc_reg + 1'b1;
				end
			end
		end
	end

	// capture register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cap_reg <= '0;
		end else if (ce && cap_evt) begin
			cap_reg <= tc_reg;
		end
	end

	// prescale limit, loaded by software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pr_reg <= '0;
		end else if (wr_done && paddr == mct_pkg::OFF_PRESCALE) begin
			pr_reg <= pwdata[W-1:0];
		end
	end

	// per-channel match actions: interrupt, reset, stop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mctrl_reg <= mct_pkg::MCTRL_RESET_VAL;
		end else if (wr_done && paddr == mct_pkg::OFF_MCTRL) begin
			mctrl_reg <= pwdata[11:0];
		end
	end

	// capture edge, interrupt and clear selection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			capctrl_reg <= mct_pkg::CAPCTRL_RESET_VAL;
		end else if (wr_done && paddr == mct_pkg::OFF_CAPCTRL) begin
			capctrl_reg <= pwdata[4:0];
		end
	end

	// output actions on match, two bits per channel
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			extact_reg <= mct_pkg::EXTM_ACT_RESET_VAL;
		end else if (wr_done && paddr == mct_pkg::OFF_EXTM) begin
			extact_reg <= pwdata[mct_pkg::EXTM_ACT_LSB +: 8];
		end
	end

	// pwm enables per output
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwm_reg <= 4'h0;
		end else if (wr_done && paddr == mct_pkg::OFF_PWM) begin
			pwm_reg <= pwdata[3:0];
		end
	end

	// interrupt mask, same layout as the status flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			imask_reg <= mct_pkg::IRQ_RESET_VAL;
		end else if (wr_done && paddr == mct_pkg::OFF_IMASK) begin
			imask_reg <= pwdata[4:0];
		end
	end

	// sticky flags; a read clears only the bits it returned, new events win
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			istat_reg <= mct_pkg::IRQ_RESET_VAL;
		end else if (ce) begin
			if (rd_done && paddr == mct_pkg::OFF_ISTAT) begin
				istat_reg <= (istat_reg & ~rd_clr_reg) | ev_set;
			end else begin
				istat_reg <= istat_reg | ev_set;
			end
		end
	end

	// level interrupt from unmasked flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(istat_reg & imask_reg);
		end
	end

	// adc trigger pulses from match and capture events
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			adc_trig_match <= 4'h0;
			adc_trig_cap <= 1'b0;
		end else if (ce) begin
			adc_trig_match <= hit;
			adc_trig_cap <= cap_evt;
		end
	end

	// read multiplexer
	always_comb begin
		rdata_next = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			mct_pkg::OFF_CTRL: rdata_next = {29'h0, ctrl_reg};
			mct_pkg::OFF_COUNT: rdata_next = 32'(tc_reg);
			mct_pkg::OFF_PRESCALE: rdata_next = 32'(pr_reg);
			mct_pkg::OFF_PSCNT: rdata_next = 32'(pc_reg);
			mct_pkg::OFF_MCTRL: rdata_next = {20'h0, mctrl_reg};
			mct_pkg::OFF_MATCH0: rdata_next = 32'(match_reg[0]);
			mct_pkg::OFF_MATCH1: rdata_next = 32'(match_reg[1]);
			mct_pkg::OFF_MATCH2: rdata_next = 32'(match_reg[2]);
			mct_pkg::OFF_MATCH3: rdata_next = 32'(match_reg[3]);
			mct_pkg::OFF_CAPCTRL: rdata_next = {27'h0, capctrl_reg};
			mct_pkg::OFF_CAPTURE: rdata_next = 32'(cap_reg);
			mct_pkg::OFF_EXTM: rdata_next = {19'h0, cap_level, extact_reg, match_out};
			mct_pkg::OFF_PWM: rdata_next = {28'h0, pwm_reg};
			mct_pkg::OFF_ISTAT: rdata_next = {27'h0, istat_reg};
			mct_pkg::OFF_IMASK: rdata_next = {27'h0, imask_reg};
			default: mapped = 1'b0;
		endcase
	end

	// apb answer: one wait state, data and error registered with ready
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			rd_clr_reg <= 5'h00;
		end else if (ce) begin
			if (psel && penable && !pready) begin
				pready <= 1'b1;
				pslverr <= !mapped;
				prdata <= pwrite ? 32'h0000_0000 : rdata_next;
				rd_clr_reg <= istat_reg;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end
endmodule

/* bench/mct_checker.sv */
module mct_checker #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic cap_in,
	input wire logic [3:0] match_out,
	input wire logic adc_trig_cap,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// bus answer timing
	rdy_wait_a: assert property (psel && penable && !pready && ce |=> pready)
		else $error("no answer after access");
	rdy_pulse_a: assert property (pready && ce |=> !pready)
		else $error("ready longer than a cycle");
	rdy_psel_a: assert property (pready |-> psel && penable)
		else $error("ready outside a transfer");
	err_rdy_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	// events and flags
	cap_quiet_a: assert property ($stable(cap_in) [*8] |=> !adc_trig_cap)
		else $error("capture trigger without pin change");
	irq_hold_a: assert property (irq && !psel && !pready && !$past(pready) |=> irq)
		else $error("interrupt dropped without access");
	rst_out_a: assert property ($fell(sys_rst) |-> match_out == 4'h0 && !irq)
		else $error("outputs not cleared by reset");
	freeze_a: assert property (!ce |=> $stable(match_out) && $stable(irq))
		else $error("outputs moved while halted");

	// main scenarios
	cover property ($rose(irq));
	cover property (adc_trig_cap);
	cover property (pslverr);
endmodule

bind mct_timer mct_checker #(.W(W)) i_chk (
	.clk(clk),
	.sys_rst(sys_rst),
	.ce(ce),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.cap_in(cap_in),
	.match_out(match_out),
	.adc_trig_cap(adc_trig_cap),
	.irq(irq)
);

/* bench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cap_in = 1'b0;
	logic [3:0] match_out;
	logic [3:0] adc_trig_match;
	logic adc_trig_cap;
	logic irq;
	logic [31:0] rd_data;
	logic rd_err;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int trig_hits = 0;
	int cap_hits = 0;
	int trig_base = 0;

	mct_timer #(.W(16)) i_dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cap_in(cap_in),
		.match_out(match_out),
		.adc_trig_match(adc_trig_match),
		.adc_trig_cap(adc_trig_cap),
		.irq(irq)
	);

	// clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			give_verdict();
		end
	end

	// count one-cycle trigger pulses while they stand
	always @(posedge clk) begin
		if (adc_trig_match[0] === 1'b1) begin
			trig_hits <= trig_hits + 1;
		end
		if (adc_trig_cap === 1'b1) begin
			cap_hits <= cap_hits + 1;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd_data, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// main sequence
	initial begin
		idle(8);
		sys_rst <= 1'b0;
		rd(mct_pkg::OFF_CTRL, 32'h0);
		rd(mct_pkg::OFF_IMASK, 32'h0);
		rd(8'h3C, 32'h0);
		check(32'(rd_err), 32'h1);
		// reset on match, sticky flag, freeze
		wr(mct_pkg::OFF_IMASK, 32'h1F);
		wr(mct_pkg::OFF_MATCH0, 32'h3);
		wr(mct_pkg::OFF_MCTRL, 32'h3);
		wr(mct_pkg::OFF_CTRL, 32'h1);
		idle(20);
		check(32'(irq), 32'h1);
		apb(1'b0, mct_pkg::OFF_COUNT, 32'h0);
		check(32'(rd_err), 32'h0);
		check(32'(rd_data < 4), 32'h1);
		ce <= 1'b0;
		idle(3);
		ce <= 1'b1;
		wr(mct_pkg::OFF_CTRL, 32'h0);
		rd(mct_pkg::OFF_ISTAT, 32'h1);
		rd(mct_pkg::OFF_ISTAT, 32'h0);
		idle(3);
		check(32'(irq), 32'h0);
		// stop on match with prescaler, then capture
		wr(mct_pkg::OFF_PRESCALE, 32'h1);
		wr(mct_pkg::OFF_COUNT, 32'h0);
		wr(mct_pkg::OFF_MCTRL, 32'h28);
		wr(mct_pkg::OFF_MATCH1, 32'h5);
		wr(mct_pkg::OFF_CTRL, 32'h1);
		idle(40);
		rd(mct_pkg::OFF_COUNT, 32'h5);
		rd(mct_pkg::OFF_CTRL, 32'h0);
		wr(mct_pkg::OFF_CAPCTRL, 32'h5);
		cap_in <= 1'b1;
		idle(8);
		rd(mct_pkg::OFF_CAPTURE, 32'h5);
		rd(mct_pkg::OFF_ISTAT, 32'h12);
		// clear on falling edge
		wr(mct_pkg::OFF_CAPCTRL, 32'h10);
		cap_in <= 1'b0;
		idle(8);
		rd(mct_pkg::OFF_COUNT, 32'h0);
		check(32'(cap_hits), 32'h1);
		// every output action, state starts high
		wr(mct_pkg::OFF_MATCH0, 32'h2);
		trig_base = trig_hits;
		for (int i = 0; i < 4; i++) begin
			wr(mct_pkg::OFF_EXTM, 32'((i << 4) | 1));
			wr(mct_pkg::OFF_COUNT, 32'h0);
			wr(mct_pkg::OFF_MCTRL, 32'h4);
			wr(mct_pkg::OFF_CTRL, 32'h1);
			idle(20);
			check(32'(match_out[0]), 32'(i % 2 == 0));
		end
		check(32'(trig_hits - trig_base), 32'h4);
		// pwm level against held count of two
		wr(mct_pkg::OFF_PWM, 32'h1);
		wr(mct_pkg::OFF_MATCH0, 32'h3);
		idle(3);
		check(32'(match_out[0]), 32'h0);
		wr(mct_pkg::OFF_MATCH0, 32'h2);
		idle(3);
		check(32'(match_out[0]), 32'h1);
		// counter mode: rising capture edges advance the count
		wr(mct_pkg::OFF_MCTRL, 32'h0);
		wr(mct_pkg::OFF_CAPCTRL, 32'h1);
		wr(mct_pkg::OFF_COUNT, 32'h0);
		wr(mct_pkg::OFF_CTRL, 32'h5);
		repeat (2) begin
			cap_in <= 1'b1;
			idle(6);
			cap_in <= 1'b0;
			idle(6);
		end
		rd(mct_pkg::OFF_COUNT, 32'h2);
		check(32'(cap_hits), 32'h3);
		// hold-reset bit clears, then a limit of three gives a tick every four cycles
		wr(mct_pkg::OFF_CTRL, 32'h2);
		rd(mct_pkg::OFF_COUNT, 32'h0);
		wr(mct_pkg::OFF_PRESCALE, 32'h3);
		wr(mct_pkg::OFF_CTRL, 32'h1);
		idle(12);
		rd(mct_pkg::OFF_COUNT, 32'h3);
		rd(mct_pkg::OFF_PSCNT, 32'h2);
		give_verdict();
	end
endmodule
